// ---- logic/scg_pkg.sv ----
package scg_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLK_GATE   = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    // sleep control fields and reset value
    localparam int         SCR_ARM_BIT  = 0;
    localparam int         SCR_MODE_LSB = 1;
    localparam int         SCR_MODE_MSB = 3;
    localparam logic [7:0] SCR_RESET    = 8'h00;
    // sleep mode encodings
    localparam logic [2:0] MODE_IDLE  = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_STBY  = 3'h6;
    // module clock gate bit positions
    localparam int         G_PSC2 = 7;
    localparam int         G_PSC1 = 6;
    localparam int         G_PSC0 = 5;
    localparam int         G_TIMB = 4;
    localparam int         G_TIMA = 3;
    localparam int         G_SPI  = 2;
    localparam int         G_NONE = 1;
    localparam int         G_ADC  = 0;
    localparam logic [7:0] GATE_WMASK = 8'hfd;
    localparam logic [7:0] GATE_RESET = 8'h00;
    // status register fields
    localparam int         ST_STATE_LSB = 0;
    localparam int         ST_EXTCONV   = 8;
    localparam int         ST_VREF      = 9;
    // clock option fuses: codes at or above this select a crystal
    localparam logic [3:0] FUSE_XTAL_MIN = 4'h8;
    // wake timing in cycles
    localparam int         CNT_W           = 16;
    localparam int         STALL_CYC       = 4;
    localparam int         STBY_RESUME_CYC = 6;
    localparam int         STBY_START_CYC  = STBY_RESUME_CYC - STALL_CYC - 1;
    // controller states, one-hot
    typedef enum logic [6:0] {
        S_ACTIVE = 7'h01,
        S_IDLE   = 7'h02,
        S_ADCNR  = 7'h04,
        S_PDOWN  = 7'h08,
        S_STBY   = 7'h10,
        S_WAIT   = 7'h20,
        S_STALL  = 7'h40
    } scg_state_type;
endpackage : scg_pkg

// ---- logic/scg_wake_timer.sv ----
`timescale 1ns/100ps
// down counter used for start-up and stall delays
module scg_wake_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // load request
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // status
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_r;    // cycles still to wait
    logic [W-1:0] cnt_nxt;  // next count

    // load wins, otherwise count down to zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
        begin
            cnt_nxt = load_val;
        end
        else if (cnt_r != '0)
        begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    // counter register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // last waiting cycle flags done
    assign busy = (cnt_r != '0);
    assign done = (cnt_r == W'(1));
endmodule : scg_wake_timer

// ---- logic/scg_sleep_gating.sv ----
// Behaviour
// [RULE1] mode 010 plus halt enters power-down
// [RULE2] power-down stops every generated clock
// [RULE3] power-down wakes on few listed sources
// [RULE4] level wake source holds level long enough
// [RULE5] power-down wake waits fuse-selected start-up
// [RULE6] mode 110 with crystal enters standby
// [RULE7] standby wake resumes within six cycles
// [RULE8] active clock domains per sleep mode
// [RULE9] allowed wake sources per sleep mode
// [RULE10] gate bit stops clock, blocks registers
// [RULE11] clearing gate bit restarts frozen module
// [RULE12] software disables peripheral before gating
// [RULE13] bits 7..5 gate power stage controllers
// [RULE14] bit 2 gates serial, bit 0 converter
// [RULE15] bits 4,3 gate timer b, a
// [RULE16] software disables converter before gating
// [RULE17] gated converter blocks comparator mux use
// [RULE18] module gating acts in active, idle
// [RULE19] converter stays on; restart gives extended conversion
// [RULE20] deep sleep disables comparator unless using reference
// [RULE21] fused brown-out detector stays on always
// [RULE22] reference on only when a user needs it
// [RULE23] sleep needs arm bit then halt
// [RULE24] interrupt wake stalls four cycles after start-up
// [RULE25] gate bit 1 ignores writes, reads zero
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
module scg_sleep_gating #(
    parameter logic [15:0] TOUT_SHORT_CYC = 16'h0040,  // start-up, internal clock
    parameter logic [15:0] TOUT_LONG_CYC  = 16'h4000   // start-up, crystal
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu side
    input  wire logic        halt_exec,
    output logic             cpu_stall,
    output logic             wake_resume,
    // wake sources, same clock, level
    input  wire logic        wake_psc,
    input  wire logic        wake_spm,
    input  wire logic        wake_adc,
    input  wire logic        wake_wdt,
    input  wire logic        wake_other,
    // external interrupt pins and their trigger setup
    input  wire logic [3:0]  ext_irq_lines,
    input  wire logic [3:0]  ext_irq_is_level,
    // fuses and analog setup
    input  wire logic [3:0]  clock_source_fuses,
    input  wire logic        bod_fuse_enable,
    input  wire logic        adc_enable,
    input  wire logic        adc_conv_done,
    input  wire logic        acomp_enable,
    input  wire logic        acomp_uses_ref,
    // clock domain enables
    output logic             cpu_clk_en,
    output logic             flash_clk_en,
    output logic             io_clk_en,
    output logic             adc_clk_en,
    output logic             pll_clk_en,
    output logic             osc_en,
    // per-module clocks and register blocking
    output logic      [7:0]  mod_clk_en,
    output logic      [7:0]  mod_reg_block,
    // analog control
    output logic             acomp_mux_allow,
    output logic             acomp_power_en,
    output logic             adc_power_en,
    output logic             adc_ext_conv,
    output logic             bod_en,
    output logic             vref_en
);
    scg_pkg::scg_state_type st_r;      // controller state
    scg_pkg::scg_state_type st_nxt;    // next state
    logic [7:0]  scr_r;                // sleep control register
    logic [7:0]  gate_r;               // module clock gate register
    logic [3:0]  irq_s1_r;             // pin synchroniser, first stage
    logic [3:0]  irq_s2_r;             // pin synchroniser, second stage
    logic        adc_en_d_r;           // previous converter enable
    logic        tmr_load;             // start a delay
    logic [15:0] tmr_val;              // delay length
    logic        tmr_done;             // delay on its last cycle
    logic        is_xtal;              // crystal clock option
    logic        arm;                  // sleep armed
    logic [2:0]  mode;                 // selected sleep mode
    logic        wake_any;             // any source, idle
    logic        wake_nr;              // noise reduction sources
    logic        wake_pd;              // power-down sources
    logic        wake_sb;              // standby sources
    logic        ext_lvl;              // level external irq active
    logic        deep;                 // comparator auto-off state
    logic [5:0]  dom_nxt;              // cpu,flash,io,adc,pll,osc
    logic        setup;                // apb setup phase
    logic        wr_acc;               // write taken this edge
    logic [31:0] rd_nxt;               // read data for setup phase
    logic        err_nxt;              // unmapped address

    assign is_xtal  = (clock_source_fuses >= scg_pkg::FUSE_XTAL_MIN);
    assign arm      = scr_r[scg_pkg::SCR_ARM_BIT];
    assign mode     = scr_r[scg_pkg::SCR_MODE_MSB:scg_pkg::SCR_MODE_LSB];
    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite & pready;

    // only level-triggered external lines may wake deep modes
    assign ext_lvl  = |(irq_s2_r & ext_irq_is_level); // [RULE9]
    assign wake_any = (|irq_s2_r) | wake_psc | wake_spm | wake_adc | wake_wdt | wake_other;
    assign wake_nr  = ext_lvl | wake_psc | wake_spm | wake_adc | wake_wdt; // [RULE9]
    assign wake_pd  = ext_lvl | wake_psc | wake_wdt; // [RULE3]
    assign wake_sb  = ext_lvl | wake_wdt; // [RULE9]

    // external pins pass two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_s1_r <= 4'h0;
            irq_s2_r <= 4'h0;
        end
        else
        begin
            irq_s1_r <= ext_irq_lines;
            irq_s2_r <= irq_s1_r;
        end
    end

    // sleep entry, wake and resume sequencing
    always_comb
    begin
        st_nxt   = st_r;
        tmr_load = 1'b0;
        tmr_val  = 16'h0000;
        case (st_r)
            scg_pkg::S_ACTIVE:
            begin
                // halt without arm has no sleep effect
                if (halt_exec && arm) // [RULE23]
                begin
                    case (mode)
                        scg_pkg::MODE_IDLE:  st_nxt = scg_pkg::S_IDLE;
                        scg_pkg::MODE_ADCNR: st_nxt = scg_pkg::S_ADCNR;
                        scg_pkg::MODE_PDOWN: st_nxt = scg_pkg::S_PDOWN; // [RULE1]
                        scg_pkg::MODE_STBY:
                        begin
                            if (is_xtal) // [RULE6]
                            begin
                                st_nxt = scg_pkg::S_STBY;
                            end
                        end
                        default: st_nxt = scg_pkg::S_ACTIVE;
                    endcase
                end
            end
            scg_pkg::S_IDLE:
            begin
                // clocks running, stall only
                if (wake_any) // [RULE9]
                begin
                    st_nxt   = scg_pkg::S_STALL;
                    tmr_load = 1'b1;
                    tmr_val  = 16'(scg_pkg::STALL_CYC);
                end
            end
            scg_pkg::S_ADCNR:
            begin
                // main source still runs
                if (wake_nr)
                begin
                    st_nxt   = scg_pkg::S_STALL;
                    tmr_load = 1'b1;
                    tmr_val  = 16'(scg_pkg::STALL_CYC);
                end
            end
            scg_pkg::S_PDOWN:
            begin
                // oscillator must restart: fuse-selected time-out
                if (wake_pd) // [RULE3]
                begin
                    st_nxt   = scg_pkg::S_WAIT;
                    tmr_load = 1'b1;
                    tmr_val  = is_xtal ? TOUT_LONG_CYC : TOUT_SHORT_CYC; // [RULE5]
                end
            end
            scg_pkg::S_STBY:
            begin
                // oscillator kept running, short restart
                if (wake_sb)
                begin
                    st_nxt   = scg_pkg::S_WAIT;
                    tmr_load = 1'b1;
                    tmr_val  = 16'(scg_pkg::STBY_START_CYC); // [RULE7]
                end
            end
            scg_pkg::S_WAIT:
            begin
                // start-up over, then fixed stall
                if (tmr_done)
                begin
                    st_nxt   = scg_pkg::S_STALL;
                    tmr_load = 1'b1;
                    tmr_val  = 16'(scg_pkg::STALL_CYC); // [RULE24]
                end
            end
            scg_pkg::S_STALL:
            begin
                // resume after the halt instruction
                if (tmr_done) // [RULE24]
                begin
                    st_nxt = scg_pkg::S_ACTIVE;
                end
            end
            default: st_nxt = scg_pkg::S_ACTIVE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= scg_pkg::S_ACTIVE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // delay counter for start-up and stall
    scg_wake_timer #(
        .W        (scg_pkg::CNT_W)
    ) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .busy     (),
        .done     (tmr_done)
    );

    // domain enables follow the next state
    always_comb
    begin
        case (st_nxt)
            scg_pkg::S_ACTIVE: dom_nxt = 6'h3f;
            scg_pkg::S_IDLE:   dom_nxt = 6'h0f; // [RULE8]
            scg_pkg::S_ADCNR:  dom_nxt = 6'h07; // [RULE8]
            scg_pkg::S_PDOWN:  dom_nxt = 6'h00; // [RULE2]
            scg_pkg::S_STBY:   dom_nxt = 6'h01; // [RULE8]
            scg_pkg::S_WAIT:   dom_nxt = 6'h01;
            scg_pkg::S_STALL:  dom_nxt = 6'h0f;
            default:           dom_nxt = 6'h3f;
        endcase
    end

    // comparator is switched off in the deeper modes unless it uses the reference
    assign deep = (st_nxt == scg_pkg::S_PDOWN) || (st_nxt == scg_pkg::S_STBY)
                || (st_nxt == scg_pkg::S_WAIT);

    // registered clock and analog outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {cpu_clk_en, flash_clk_en, io_clk_en} <= 3'h7;
            {adc_clk_en, pll_clk_en, osc_en}      <= 3'h7;
            cpu_stall      <= 1'b0;
            wake_resume    <= 1'b0;
            acomp_power_en <= 1'b0;
            adc_power_en   <= 1'b0;
            bod_en         <= 1'b0;
            vref_en        <= 1'b0;
        end
        else
        begin
            {cpu_clk_en, flash_clk_en, io_clk_en} <= dom_nxt[5:3];
            {adc_clk_en, pll_clk_en, osc_en}      <= dom_nxt[2:0]; // [RULE1]
            cpu_stall      <= (st_nxt != scg_pkg::S_ACTIVE);
            wake_resume    <= (st_r == scg_pkg::S_STALL) && tmr_done;
            acomp_power_en <= acomp_enable && !(deep && !acomp_uses_ref); // [RULE20]
            adc_power_en   <= adc_enable; // [RULE19]
            bod_en         <= bod_fuse_enable; // [RULE21]
            vref_en        <= bod_fuse_enable || adc_enable
                           || (acomp_enable && acomp_uses_ref); // [RULE22]
        end
    end

    // per-module clocks: gate bit and owning domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mod_clk_en      <= scg_pkg::GATE_WMASK;
            mod_reg_block   <= scg_pkg::GATE_RESET;
            acomp_mux_allow <= 1'b1;
        end
        else
        begin
            mod_clk_en[scg_pkg::G_PSC2] <= !gate_r[scg_pkg::G_PSC2] && pll_clk_en; // [RULE13]
            mod_clk_en[scg_pkg::G_PSC1] <= !gate_r[scg_pkg::G_PSC1] && pll_clk_en; // [RULE13]
            mod_clk_en[scg_pkg::G_PSC0] <= !gate_r[scg_pkg::G_PSC0] && pll_clk_en; // [RULE13]
            mod_clk_en[scg_pkg::G_TIMB] <= !gate_r[scg_pkg::G_TIMB] && io_clk_en; // [RULE15]
            mod_clk_en[scg_pkg::G_TIMA] <= !gate_r[scg_pkg::G_TIMA] && io_clk_en; // [RULE15]
            mod_clk_en[scg_pkg::G_SPI]  <= !gate_r[scg_pkg::G_SPI] && io_clk_en; // [RULE14]
            mod_clk_en[scg_pkg::G_NONE] <= 1'b0;
            mod_clk_en[scg_pkg::G_ADC]  <= !gate_r[scg_pkg::G_ADC] && adc_clk_en; // [RULE18]
            // frozen modules refuse register access; clear restores both
            mod_reg_block   <= gate_r; // [RULE10] [RULE11]
            acomp_mux_allow <= !gate_r[scg_pkg::G_ADC]; // [RULE17]
        end
    end

    // extended conversion flag: restart sets, conversion clears, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_en_d_r   <= 1'b0;
            adc_ext_conv <= 1'b1;
        end
        else
        begin
            adc_en_d_r <= adc_enable;
            if (adc_enable && !adc_en_d_r) // [RULE19]
            begin
                adc_ext_conv <= 1'b1;
            end
            else if (adc_conv_done)
            begin
                adc_ext_conv <= 1'b0;
            end
        end
    end

    // software registers, written at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scr_r  <= scg_pkg::SCR_RESET;
            gate_r <= scg_pkg::GATE_RESET;
        end
        else if (wr_acc)
        begin
            if (paddr == scg_pkg::ADDR_SLEEP_CTRL)
            begin
                scr_r <= pwdata[7:0] & 8'h0f; // [RULE23]
            end
            else if (paddr == scg_pkg::ADDR_CLK_GATE)
            begin
                gate_r <= pwdata[7:0] & scg_pkg::GATE_WMASK; // [RULE25]
            end
        end
    end

    // read mux and decode, evaluated in the setup phase
    always_comb
    begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            scg_pkg::ADDR_SLEEP_CTRL: rd_nxt[7:0] = scr_r;
            scg_pkg::ADDR_CLK_GATE:   rd_nxt[7:0] = gate_r; // [RULE25]
            scg_pkg::ADDR_STATUS:
            begin
                rd_nxt[scg_pkg::ST_STATE_LSB +: 7] = st_r;
                rd_nxt[scg_pkg::ST_EXTCONV]        = adc_ext_conv;
                rd_nxt[scg_pkg::ST_VREF]           = vref_en;
            end
            default: err_nxt = 1'b1;
        endcase
    end

    // apb answer: one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && err_nxt;
            prdata  <= setup ? rd_nxt : 32'h0000_0000;
        end
    end

    AST_ENTER_PDOWN: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        (st_r == scg_pkg::S_ACTIVE && halt_exec && arm && mode == scg_pkg::MODE_PDOWN)
        |=> (st_r == scg_pkg::S_PDOWN && !osc_en))
        else $error("power-down not entered");
    AST_NO_ARM: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        (st_r == scg_pkg::S_ACTIVE && halt_exec && !arm) |=> st_r == scg_pkg::S_ACTIVE)
        else $error("sleep entered without arm");
    AST_PDOWN_DARK: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        (st_r == scg_pkg::S_PDOWN) |-> !(cpu_clk_en || io_clk_en || adc_clk_en
        || pll_clk_en || osc_en))
        else $error("clock running in power-down");
    AST_PDOWN_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        (st_r == scg_pkg::S_PDOWN && !wake_pd) |=> st_r == scg_pkg::S_PDOWN)
        else $error("power-down left without wake source");
    AST_STBY_SIX: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        (st_r == scg_pkg::S_STBY && wake_sb) |-> ##6 st_r == scg_pkg::S_ACTIVE)
        else $error("standby resume not six cycles");
    AST_STALL_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
        $rose(st_r == scg_pkg::S_STALL) |-> (st_r == scg_pkg::S_STALL) [*4]
        ##1 (st_r == scg_pkg::S_ACTIVE && wake_resume))
        else $error("stall not four cycles");
    AST_SPI_GATED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        gate_r[scg_pkg::G_SPI] |=> !mod_clk_en[scg_pkg::G_SPI] && mod_reg_block[scg_pkg::G_SPI])
        else $error("gated serial clock still running");
    AST_MUX_BLOCK: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        gate_r[scg_pkg::G_ADC] |=> !acomp_mux_allow)
        else $error("comparator mux allowed while converter gated");
    AST_BIT1_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE25]
        wr_acc && paddr == scg_pkg::ADDR_CLK_GATE |=> !gate_r[scg_pkg::G_NONE])
        else $error("gate bit 1 stored");
endmodule : scg_sleep_gating

// ---- tb/scg_cpu_model.sv ----
`timescale 1ns/100ps
// cpu core and interrupt sources facing the sleep controller
module scg_cpu_model (
    // clock
    input  wire logic pclk,
    // halt pulse and wake levels: psc, spm, adc, wdt, other
    output logic       halt_exec,
    output logic [4:0] wake_v
);
    // quiet at time zero
    initial
    begin
        halt_exec = 1'b0;
        wake_v    = 5'h00;
    end
    // one-cycle halt, issued after a sleep control register write
    task halt;
        @(posedge pclk) halt_exec <= 1'b1;
        @(posedge pclk) halt_exec <= 1'b0;
    endtask : halt
    // raise one wake level, hold it three cycles so the controller samples it
    task wake(input int i);
        @(posedge pclk) wake_v[i] <= 1'b1;
        fork
            begin
                repeat (3) @(posedge pclk);
                wake_v <= 5'h00;
            end
        join_none
    endtask : wake
endmodule : scg_cpu_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
    localparam int         TL     = 5;
    localparam logic [2:0] MD [4] = '{scg_pkg::MODE_IDLE, scg_pkg::MODE_ADCNR,
                                      scg_pkg::MODE_PDOWN, scg_pkg::MODE_STBY};
    localparam int         SRC[4] = '{4, 2, 0, 3};
    localparam int         EXP[4] = '{6, 6, TL + 6, 7};
    localparam logic [5:0] DOM[4] = '{6'h0f, 6'h07, 6'h00, 6'h01};
    // bus and control drive
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, g, mce, mrb;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, halt_exec, cpu_stall, wake_resume;
    logic [4:0]  wake_v;
    logic [3:0]  irq = 4'h0, lvl = 4'ha;  // pins; lines 1 and 3 level-triggered
    logic        adc_en = 1'b0, ac_en = 1'b0, ac_ref = 1'b0, bod = 1'b0, cdone = 1'b0;
    logic        cc, fc, ic, ac, lc, oc, mux_ok, ac_pw, adc_pw, ext_cv, bod_en, vref_en;
    int          fails = 0, cmp_count = 0, cyc = 0, n;
    // 50 ns clock
    always #25 pclk = ~pclk;
    scg_cpu_model cpu (.pclk(pclk), .halt_exec(halt_exec), .wake_v(wake_v));
    scg_sleep_gating #(.TOUT_SHORT_CYC(16'h0003), .TOUT_LONG_CYC(16'h0005)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_exec(halt_exec), .cpu_stall(cpu_stall),
        .wake_resume(wake_resume), .wake_psc(wake_v[0]), .wake_spm(wake_v[1]),
        .wake_adc(wake_v[2]), .wake_wdt(wake_v[3]), .wake_other(wake_v[4]),
        .ext_irq_lines(irq), .ext_irq_is_level(lvl), .clock_source_fuses(4'h8),
        .bod_fuse_enable(bod), .adc_enable(adc_en), .adc_conv_done(cdone),
        .acomp_enable(ac_en), .acomp_uses_ref(ac_ref), .cpu_clk_en(cc),
        .flash_clk_en(fc), .io_clk_en(ic), .adc_clk_en(ac), .pll_clk_en(lc),
        .osc_en(oc), .mod_clk_en(mce), .mod_reg_block(mrb), .acomp_mux_allow(mux_ok),
        .acomp_power_en(ac_pw), .adc_power_en(adc_pw), .adc_ext_conv(ext_cv),
        .bod_en(bod_en), .vref_en(vref_en));
    // verdict and end of run
    task wrap_up;
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // one compare against the bench model
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk) penable <= 1'b1;
        // request held until pready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            wrap_up;
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h2fbd));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, scg_pkg::ADDR_CLK_GATE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        // gate register with converter disabled first
        for (int k = 0; k < 5; k++)
        begin
            g = (k == 4) ? 8'hff : 8'($urandom);
            apb(1'b1, scg_pkg::ADDR_CLK_GATE, {24'h0, g});
            apb(1'b0, scg_pkg::ADDR_CLK_GATE, 32'h0);
            chk(rd, g & 8'hfd);
            chk(mce, ~g & 8'hfd);
            chk(mrb, g & 8'hfd);
            chk(mux_ok, !g[0]);
        end
        apb(1'b1, scg_pkg::ADDR_CLK_GATE, 32'h0);
        @(negedge pclk);
        chk(mce, 8'hfd);
        // analog enables while active
        for (int k = 0; k < 8; k++)
        begin
            @(posedge pclk);
            {adc_en, ac_en, ac_ref, bod} <= 4'($urandom);
            @(posedge pclk);
            @(negedge pclk);
            chk({vref_en, bod_en, ac_pw}, {bod | adc_en | (ac_en & ac_ref), bod, ac_en});
        end
        // halt without arm, then armed with a reserved mode: no sleep
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            apb(1'b1, scg_pkg::ADDR_SLEEP_CTRL, k ? 32'h7 : 32'h4);
            cpu.halt();
            repeat (3) @(negedge pclk);
            chk(cpu_stall, 1'b0);
        end
        // each sleep mode, entry, domains, accepted wake; refused wake in power-down and standby
        for (int k = 0; k < 4; k++)
        begin
            @(posedge pclk);
            {adc_en, ac_en, ac_ref} <= {2'b11, k[0]};
            apb(1'b1, scg_pkg::ADDR_SLEEP_CTRL, {28'h0, MD[k], 1'b1});
            cpu.halt();
            repeat (3) @(negedge pclk);
            chk({cc, fc, ic, ac, lc, oc, cpu_stall}, {DOM[k], 1'b1});
            chk({ac_pw, adc_pw}, {k < 2 || ac_ref, 1'b1});
            if (k >= 2)
            begin
                cpu.wake(1);
                irq <= 4'h5;  // edge-type lines only
                repeat (8) @(negedge pclk);
                chk(cpu_stall, 1'b1);
                @(posedge pclk);
                irq <= 4'h0;
            end
            cpu.wake(SRC[k]);
            n = 0;
            do
            begin
                @(negedge pclk);
                n++;
            end
            while (wake_resume !== 1'b1 && n < 40);
            chk(n, EXP[k]);
        end
        // level line wakes power-down, two synchroniser cycles later
        @(posedge pclk);
        apb(1'b1, scg_pkg::ADDR_SLEEP_CTRL, {28'h0, scg_pkg::MODE_PDOWN, 1'b1});
        cpu.halt();
        irq <= 4'h2;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (wake_resume !== 1'b1 && n < 40);
        chk(n, TL + 8);
        // reset in mid power-down wakes and restores defaults
        @(posedge pclk);
        irq <= 4'h0;
        apb(1'b1, scg_pkg::ADDR_SLEEP_CTRL, {28'h0, scg_pkg::MODE_PDOWN, 1'b1});
        cpu.halt();
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({cpu_stall, oc, mce, mrb, ext_cv}, {2'b01, 8'hfd, 8'h00, 1'b1});
        presetn <= 1'b1;
        // conversion clears the extended flag, restart sets it
        @(posedge pclk);
        cdone <= 1'b1;
        @(posedge pclk);
        cdone <= 1'b0;
        apb(1'b0, scg_pkg::ADDR_STATUS, 32'h0);
        chk(rd[9:0], {2'b10, 1'b0, 7'(scg_pkg::S_ACTIVE)});
        adc_en <= 1'b0;
        @(posedge pclk);
        adc_en <= 1'b1;
        repeat (2) @(negedge pclk);
        chk(ext_cv, 1'b1);
        wrap_up;
    end
endmodule : tb
